// ==== sim/prs_core_monitor.sv ====
// Port checker for the program counter and return stack unit
`timescale 1ns/10ps
module prs_core_monitor
    import prs_pkg::*;
(
    // Clock and reset
    input wire logic            sys_clk,
    input wire logic            resetn,
    // Core side
    input wire logic            devResetReq,
    input wire prs_req_s        coreReq,
    input wire logic [15:0]     memWord,
    input wire logic [15:0]     instrWord,
    input wire logic [PC_W-1:0] pcOut,
    input wire logic            restoreValid,
    input wire logic            stackErrReset,
    // Register port
    input wire prs_bus_s        regBus,
    input wire logic [7:0]      regRdata
);
    // No competing counter load this cycle, since resets and low writes win
    logic quiet;
    assign quiet = !devResetReq && !stackErrReset
                   && !(regBus.wr && regBus.addr == OFF_CNT_LOW);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Any return kind asking for the fast restore
    sequence s_fastRet;
        coreReq.fast && coreReq.op inside {OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT};
    endsequence
    // Error pulse then counter back at the start address
    sequence s_errDone;
        !stackErrReset ##[0:1] pcOut == RESET_VEC;
    endsequence
    property p_bitZero; pcOut[0] == 1'b0; endproperty
    property p_advance;
        coreReq.op == OP_ADVANCE && quiet |=> pcOut == $past(pcOut) + FETCH_STEP;
    endproperty
    property p_jump;
        coreReq.op == OP_JUMP && quiet |=> pcOut == ($past(coreReq.target) & ~21'h1);
    endproperty
    property p_vector;
        coreReq.op == OP_INTACK && quiet
        |=> pcOut == ($past(coreReq.hiPri) ? INT_VEC_HI : INT_VEC_LO);
    endproperty
    property p_highFetch; pcOut > KERNEL_TOP |=> instrWord == 16'h0000; endproperty
    property p_lowFetch;
        pcOut <= KERNEL_TOP && !devResetReq |=> instrWord == $past(memWord);
    endproperty
    property p_idleRead; !regBus.rd |=> regRdata == 8'h00; endproperty
    property p_ptrBit5;
        regBus.rd && regBus.addr == OFF_STACK_PTR |=> regRdata[5] == 1'b0;
    endproperty
    property p_unmapped; regBus.rd && regBus.addr > OFF_CONFIG |=> regRdata == 8'h00; endproperty
    property p_devReset; devResetReq |=> pcOut == RESET_VEC; endproperty
    property p_errReset; stackErrReset |=> s_errDone; endproperty
    property p_fastRet; s_fastRet |=> restoreValid; endproperty
    a_bitZero: assert property (p_bitZero) else $error("counter bit zero set");
    a_advance: assert property (p_advance) else $error("advance step wrong");
    a_jump: assert property (p_jump) else $error("jump target not loaded");
    a_vector: assert property (p_vector) else $error("interrupt vector wrong");
    a_highFetch: assert property (p_highFetch) else $error("high fetch not zero");
    a_lowFetch: assert property (p_lowFetch) else $error("fetch word wrong");
    a_idleRead: assert property (p_idleRead) else $error("read data without read");
    a_ptrBit5: assert property (p_ptrBit5) else $error("pointer bit 5 set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_devReset: assert property (p_devReset) else $error("device reset missed");
    a_errReset: assert property (p_errReset) else $error("error reset wrong");
    a_fastRet: assert property (p_fastRet) else $error("fast restore missing");
endmodule

bind prs_core prs_core_monitor i_mon (.sys_clk, .resetn, .devResetReq, .coreReq, .memWord,
    .instrWord, .pcOut, .restoreValid, .stackErrReset, .regBus, .regRdata);

// ==== sim/prs_core_tb_top.sv ====
// Self-checking bench for the program counter and return stack unit
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errTotal++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module prs_core_tb_top import prs_pkg::*;;
    logic            sys_clk, resetn, devResetReq, restoreValid, stackErrReset;
    prs_bus_s        regBus;
    prs_req_s        coreReq;
    prs_shadow_s     coreRegs, restoreRegs;
    logic [15:0]     memWord, instrWord;
    logic [PC_W-1:0] pcOut;
    logic [7:0]      regRdata, d;
    int              errTotal = 0, samplesChecked = 0, cycles = 0;
    prs_core i_dut (.sys_clk, .resetn, .devResetReq, .coreReq, .coreRegs, .memWord,
        .instrWord, .pcOut, .restoreRegs, .restoreValid, .stackErrReset, .regBus, .regRdata);
    prs_decoder_model i_dec (.sys_clk, .pcOut, .coreReq, .coreRegs, .memWord);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Verdict and end of run
    task automatic finalReport();
        $display("checks %0d errors %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errTotal++;
            finalReport();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regBus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        regBus.wr <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        regBus.rd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic op(input prs_op_e o, input logic [PC_W-1:0] t, input logic f = 1'b0);
        i_dec.issue(o, t, f, 1'b0, 24'h0);
    endtask
    task automatic tInterrupt();
        op(OP_JUMP, 21'h000125);
        i_dec.issue(OP_INTACK, 21'h0, 1'b0, 1'b1, 24'h112233);
        `CHK("hiVector", 21'h000008, pcOut)
        rd(OFF_TOP_LOW); `CHK("pushedPc", 8'h24, d)
        op(OP_RETURN_FROM_INTERRUPT, 21'h0, 1'b1);
        `CHK("restoreValid", 1'b1, restoreValid)
        `CHK("restoreRegs", 24'h112233, restoreRegs)
        `CHK("retPc", 21'h000124, pcOut)
        i_dec.issue(OP_INTACK, 21'h0, 1'b0, 1'b0, 24'h0);
        `CHK("loVector", 21'h000018, pcOut)
        op(OP_RETURN_WITH_LITERAL, 21'h0); `CHK("retlwPc", 21'h000124, pcOut)
        `CHK("noRestore", 1'b0, restoreValid)
    endtask
    task automatic tLatches();
        wr(OFF_HIGH_LATCH, 8'h12); wr(OFF_UPPER_LATCH, 8'h01);
        op(OP_CALL, 21'h000301); `CHK("callPc", 21'h000300, pcOut)
        rd(OFF_HIGH_LATCH); `CHK("latchHigh", 8'h12, d)
        op(OP_RETURN, 21'h0); rd(OFF_UPPER_LATCH); `CHK("latchUp", 8'h01, d)
        op(OP_RELATIVE_CALL, 21'h000457); `CHK("rcallPc", 21'h000456, pcOut)
        rd(OFF_TOP_LOW); `CHK("rcallTop", 8'h24, d)
        rd(OFF_HIGH_LATCH); `CHK("rcallLatch", 8'h12, d)
        op(OP_RETURN, 21'h0); `CHK("rcallRet", 21'h000124, pcOut)
        wr(OFF_CNT_LOW, 8'h35); `CHK("lowWrite", 21'h011234, pcOut)
        rd(OFF_CNT_LOW); `CHK("lowRead", 8'h34, d)
        op(OP_JUMP, 21'h0A5678); rd(OFF_CNT_LOW);
        rd(OFF_HIGH_LATCH); `CHK("copyHigh", 8'h56, d)
        rd(OFF_UPPER_LATCH); `CHK("copyUp", 8'h0A, d)
    endtask
    task automatic tFetch();
        op(OP_JUMP, 21'h008000); @(posedge sys_clk); #1;
        `CHK("highFetch", 16'h0000, instrWord)
        op(OP_JUMP, 21'h006000); @(posedge sys_clk); #1;
        `CHK("kernelFetch", 16'h3000 ^ 16'hC3A5, instrWord)
        op(OP_ADVANCE, 21'h0); `CHK("advance", 21'h006002, pcOut)
    endtask
    task automatic tStack();
        op(OP_JUMP, 21'h0002A4);
        for (int i = 0; i < 31; i++) op(OP_PUSH, 21'h0);
        rd(OFF_STACK_PTR); `CHK("fullPtr", 8'h9F, d)
        rd(OFF_TOP_LOW); `CHK("pushTop", 8'hA4, d)
        op(OP_PUSH, 21'h0); rd(OFF_STACK_PTR); `CHK("overPtr", 8'h9F, d)
        wr(OFF_STACK_PTR, 8'h1F); rd(OFF_STACK_PTR); `CHK("clearFlag", 8'h1F, d)
        for (int i = 0; i < 31; i++) op(OP_POP, 21'h0);
        `CHK("popPc", 21'h0002A4, pcOut)
        op(OP_POP, 21'h0); rd(OFF_STACK_PTR); `CHK("underPtr", 8'h40, d)
        @(posedge sys_clk) devResetReq <= 1'b1;
        @(posedge sys_clk) devResetReq <= 1'b0;
        #1 `CHK("devResetPc", 21'h0, pcOut)
        rd(OFF_STACK_PTR); `CHK("stickyFlag", 8'h40, d)
    endtask
    task automatic tErrReset();
        wr(OFF_STACK_PTR, 8'h00); wr(OFF_CONFIG, 8'h01); op(OP_JUMP, 21'h000400);
        op(OP_POP, 21'h0);
        for (int k = 0; k < 4 && stackErrReset !== 1'b1; k++) begin
            @(posedge sys_clk); #1;
        end
        `CHK("errPulse", 1'b1, stackErrReset)
        repeat (2) @(posedge sys_clk);
        #1 `CHK("errPc", 21'h0, pcOut)
        rd(OFF_STACK_PTR); `CHK("errFlag", 8'h40, d)
        for (int i = 0; i < 31; i++) op(OP_PUSH, 21'h0);
        `CHK("fullErr", 1'b1, stackErrReset)
        rd(OFF_STACK_PTR); `CHK("fullErrPtr", 8'hC0, d)
        @(posedge sys_clk) resetn <= 1'b0;
        @(posedge sys_clk) resetn <= 1'b1;
        rd(OFF_STACK_PTR); `CHK("porPtr", 8'h00, d)
        rd(OFF_CONFIG); `CHK("porConfig", 8'h00, d)
        op(OP_JUMP, 21'h000200); op(OP_RETURN, 21'h0);
        `CHK("underRetPc", 21'h0, pcOut)
        rd(OFF_STACK_PTR); `CHK("underRetPtr", 8'h40, d)
    endtask
    initial begin
        resetn = 1'b0;
        devResetReq = 1'b0;
        regBus = '0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(OFF_STACK_PTR); `CHK("resetPtr", 8'h00, d)
        rd(4'hC); `CHK("unmapped", 8'h00, d)
        `CHK("resetPc", 21'h0, pcOut)
        tInterrupt();
        tLatches();
        tFetch();
        tStack();
        tErrReset();
        finalReport();
    end
endmodule

// ==== sim/prs_decoder_model.sv ====
// Decoder and program memory stand-in driving the counter unit
`timescale 1ns/10ps
module prs_decoder_model
    import prs_pkg::*;
(
    // Clock and counter seen by memory
    input wire logic            sys_clk,
    input wire logic [PC_W-1:0] pcOut,
    // Requests towards the unit
    output prs_req_s            coreReq,
    output prs_shadow_s         coreRegs,
    output logic [15:0]         memWord
);
    // Memory answers every address, so the unit must do the gating
    assign memWord = pcOut[16:1] ^ 16'hC3A5;
    initial begin
        coreReq  = '0;
        coreRegs = '0;
    end
    // One operation held one cycle; core values scrambled afterwards
    task automatic issue(input prs_op_e op, input logic [PC_W-1:0] tgt, input logic fast,
                         input logic hi, input prs_shadow_s regs);
        @(posedge sys_clk);
        coreReq  <= '{op: op, target: tgt, fast: fast, hiPri: hi};
        coreRegs <= regs;
        @(posedge sys_clk);
        coreReq.op <= OP_NONE;
        coreRegs   <= ~regs;
        #1;
    endtask
endmodule

// ==== verilog/prs_core.sv ====
// Program counter, return address stack and fast shadow stack
`timescale 1ns/10ps
module prs_core
    import prs_pkg::*;
(
    // Clock and power-on reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // Non power-on device reset, one-cycle pulse
    input  wire logic              devResetReq,
    // Decoder and interrupt requests
    input  wire prs_req_s          coreReq,
    input  wire prs_shadow_s       coreRegs,
    // Program memory word and gated instruction
    input  wire logic [15:0]       memWord,
    output logic [15:0]            instrWord,
    // Counter and restore results
    output logic [PC_W-1:0]        pcOut,
    output prs_shadow_s            restoreRegs,
    output logic                   restoreValid,
    output logic                   stackErrReset,
    // Register port
    input  wire prs_bus_s          regBus,
    output logic [7:0]             regRdata
);

    // Whole state of the unit
    typedef struct packed {
        logic [PC_W-1:0]                  pc;
        logic [7:0]                       highLatch;
        logic [4:0]                       upperLatch;
        logic [STACK_DEPTH-1:0][PC_W-1:0] entries;
        logic [SP_W-1:0]                  index;
        logic                             fullFlag;
        logic                             underFlag;
        logic                             errResetEn;
        prs_shadow_s                      shadow;
        prs_shadow_s                      restore;
        logic                             restoreValid;
        logic                             errReset;
        logic [7:0]                       rdata;
        logic [15:0]                      instr;
    } prs_state_s;

    prs_state_s stateQ;   // Registered state
    prs_state_s stateD;   // Next state

    // Entry at a pointer, zero where the pointer has no storage
    function automatic logic [PC_W-1:0] entryAt(input prs_state_s s,
                                                input logic [SP_W-1:0] idx);
        logic [PC_W-1:0] val;
        val = '0;
        if (idx != SP_EMPTY) begin
            val = s.entries[idx - 5'h01];
        end
        return val;
    endfunction

    // Variables used by the next-state process
    logic                push;
    logic                pop;
    logic [PC_W-1:0]     pushVal;
    logic                setFull;
    logic                setUnder;
    logic [PC_W-1:0]     topVal;
    logic                busWr;
    logic                busRd;

    // Next-state process: core operation, then register access
    always_comb begin
        stateD              = stateQ;
        push                = 1'b0;
        pop                 = 1'b0;
        pushVal             = stateQ.pc;
        setFull             = 1'b0;
        setUnder            = 1'b0;
        topVal              = '0;
        busWr               = regBus.wr;
        busRd               = regBus.rd;
        stateD.restoreValid = 1'b0;
        stateD.errReset     = 1'b0;
        stateD.rdata        = 8'h00;

        // Core operation decode
        case (coreReq.op)
            OP_ADVANCE: begin
                stateD.pc = stateQ.pc + FETCH_STEP;
            end
            OP_CALL, OP_RELATIVE_CALL: begin
                push = 1'b1;
                stateD.pc = {coreReq.target[PC_W-1:1], 1'b0};
            end
            OP_JUMP: begin
                stateD.pc = {coreReq.target[PC_W-1:1], 1'b0};
            end
            OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT: begin
                pop = 1'b1;
                if (coreReq.fast) begin
                    stateD.restore      = stateQ.shadow;
                    stateD.restoreValid = 1'b1;
                end
            end
            OP_PUSH: begin
                // push keeps counter, new top entry
                push = 1'b1;
            end
            OP_POP: begin
                if (stateQ.index == SP_EMPTY) begin
                    setUnder = 1'b1;
                end else begin
                    stateD.index = stateQ.index - 5'h01;
                end
            end
            OP_INTACK: begin
                push = 1'b1;
                stateD.pc = coreReq.hiPri ? INT_VEC_HI : INT_VEC_LO;
                stateD.shadow = coreRegs;
            end
            default: begin
                // No core operation this cycle
            end
        endcase

        // Push sequence
        if (push) begin
            if (stateQ.index == SP_FULL) begin
                // Overflow: no free entry, top is not overwritten
                setFull = 1'b1;
            end else begin
                stateD.index = stateQ.index + 5'h01;
                stateD.entries[stateQ.index] = pushVal;
                // thirty-first entry marks the stack full
                if (stateQ.index + 5'h01 == SP_FULL) begin
                    setFull = 1'b1;
                end
            end
        end

        // Pop sequence
        if (pop) begin
            if (stateQ.index == SP_EMPTY) begin
                // Underflow returns to the reset vector
                setUnder  = 1'b1;
                stateD.pc = RESET_VEC;
            end else begin
                stateD.pc    = entryAt(stateQ, stateQ.index);
                stateD.index = stateQ.index - 5'h01;
            end
        end

        // Top entry as seen by software before this cycle's core operation
        topVal = entryAt(stateQ, stateQ.index);

        // Register writes
        if (busWr) begin
            case (regBus.addr)
                OFF_STACK_PTR: begin
                    // pointer field writable, bit 5 absent
                    stateD.index = regBus.wdata[SP_W-1:0];
                    // flags clear only by writing zero
                    if (!regBus.wdata[BIT_FULL]) begin
                        stateD.fullFlag = 1'b0;
                    end
                    if (!regBus.wdata[BIT_UNDER]) begin
                        stateD.underFlag = 1'b0;
                    end
                end
                OFF_TOP_LOW: begin
                    // Top entry is writable byte by byte
                    if (stateQ.index != SP_EMPTY) begin
                        stateD.entries[stateQ.index - 5'h01][7:0] = regBus.wdata;
                    end
                end
                OFF_TOP_HIGH: begin
                    if (stateQ.index != SP_EMPTY) begin
                        stateD.entries[stateQ.index - 5'h01][15:8] = regBus.wdata;
                    end
                end
                OFF_TOP_UPPER: begin
                    if (stateQ.index != SP_EMPTY) begin
                        stateD.entries[stateQ.index - 5'h01][20:16] =
                            regBus.wdata[4:0];
                    end
                end
                OFF_CNT_LOW: begin
                    // low write loads upper bits from latches
                    stateD.pc = {stateQ.upperLatch, stateQ.highLatch,
                                 regBus.wdata[7:1], 1'b0};
                end
                OFF_HIGH_LATCH: begin
                    // upper counter bytes via latches only
                    stateD.highLatch = regBus.wdata;
                end
                OFF_UPPER_LATCH: begin
                    stateD.upperLatch = regBus.wdata[4:0];
                end
                OFF_CONFIG: begin
                    stateD.errResetEn = regBus.wdata[BIT_ERREN];
                end
                default: begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // Register reads, data appear in the next cycle
        if (busRd) begin
            case (regBus.addr)
                OFF_STACK_PTR: begin
                    stateD.rdata = {stateQ.fullFlag, stateQ.underFlag, 1'b0,
                                    stateQ.index};
                end
                OFF_TOP_LOW: begin
                    stateD.rdata = topVal[7:0];
                end
                OFF_TOP_HIGH: begin
                    stateD.rdata = topVal[15:8];
                end
                OFF_TOP_UPPER: begin
                    stateD.rdata = {3'h0, topVal[20:16]};
                end
                OFF_CNT_LOW: begin
                    stateD.rdata = {stateQ.pc[7:1], 1'b0};
                    stateD.highLatch  = stateQ.pc[15:8];
                    stateD.upperLatch = stateQ.pc[20:16];
                end
                OFF_HIGH_LATCH: begin
                    stateD.rdata = stateQ.highLatch;
                end
                OFF_UPPER_LATCH: begin
                    stateD.rdata = {3'h0, stateQ.upperLatch};
                end
                OFF_CONFIG: begin
                    stateD.rdata = {7'h00, stateQ.errResetEn};
                end
                default: begin
                    // Unmapped reads return zero
                    stateD.rdata = 8'h00;
                end
            endcase
        end

        // a set in the same cycle wins over a clear
        if (setFull) begin
            stateD.fullFlag = 1'b1;
        end
        if (setUnder) begin
            stateD.underFlag = 1'b1;
        end

        // optional device reset after the flag is set
        if ((setFull || setUnder) && stateQ.errResetEn) begin
            stateD.errReset = 1'b1;
        end

        // zero above implemented memory decodes as no-op
        // kernel block passes memory data unchecked
        if (stateQ.pc > KERNEL_TOP) begin
            stateD.instr = 16'h0000;
        end else begin
            stateD.instr = memWord;
        end

        // Non power-on reset keeps flags, config and entries
        if (devResetReq || stateQ.errReset) begin
            stateD.index        = SP_EMPTY;
            // execution restarts at the reset vector
            stateD.pc           = RESET_VEC;
            stateD.highLatch    = 8'h00;
            stateD.upperLatch   = 5'h00;
            stateD.restoreValid = 1'b0;
            stateD.errReset     = 1'b0;
        end
    end

    // State register, power-on values only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // 21-bit counter starts at the reset vector
            stateQ              <= '0;
            stateQ.pc           <= RESET_VEC;
            stateQ.index        <= SP_EMPTY;
            stateQ.errResetEn   <= CONFIG_RESET[BIT_ERREN];
        end else begin
            stateQ <= stateD;
        end
    end

    // Outputs straight from flip-flops
    assign pcOut         = stateQ.pc;
    assign instrWord     = stateQ.instr;
    assign restoreRegs   = stateQ.restore;
    assign restoreValid  = stateQ.restoreValid;
    assign stackErrReset = stateQ.errReset;
    assign regRdata      = stateQ.rdata;

    // calls and returns never touch the latch fields
    // (latches change only on register access or reset above)

endmodule

// ==== verilog/prs_pkg.sv ====
// Constants and types for the program counter and return stack unit
// Summary of operation
// - Counter is 21 bits, 2 Mbyte space
// - Fetch above implemented memory returns zero
// - User memory to 5FFFh, kernel block above
// - Reset starts at 0000h, vectors 0008h/0018h
// - Stack holds up to 31 return addresses
// - Calls and interrupt acknowledge push counter
// - Returns pop top entry into counter
// - Calls and returns leave latches unchanged
// - 31x21 storage, 5-bit pointer, reset clears
// - Push increments pointer, then writes entry
// - Pop reads entry, then decrements pointer
// - Full bit7, underflow bit6, pointer bits4-0
// - Flags sticky, cleared by software or power-on
// - Push stores counter as new top
// - Pop only decrements, counter unchanged
// - Errors set flag, optionally request reset
// - Shadow captures status, working, bank on vector
// - Fast return restores the three shadow copies
// - Low byte direct, upper bytes through latches
// - Bit 0 reads zero, fetch adds 2
// - Jumps and calls load counter directly
// - Low write loads counter from latches, low read copies
package prs_pkg;

    // Counter and stack geometry
    localparam int PC_W        = 21;
    localparam int SP_W        = 5;
    localparam int STACK_DEPTH = 31;
    localparam logic [SP_W-1:0] SP_FULL  = 5'h1F;
    localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;

    // Vector and memory map addresses
    localparam logic [PC_W-1:0] RESET_VEC   = 21'h000000;
    localparam logic [PC_W-1:0] INT_VEC_HI  = 21'h000008;
    localparam logic [PC_W-1:0] INT_VEC_LO  = 21'h000018;
    localparam logic [PC_W-1:0] USER_TOP    = 21'h005FFF;
    localparam logic [PC_W-1:0] KERNEL_TOP  = 21'h007FFF;
    localparam logic [PC_W-1:0] FETCH_STEP  = 21'h000002;

    // Register offsets on the plain register port
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_STACK_PTR   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_TOP_LOW     = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_TOP_HIGH    = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_TOP_UPPER   = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_CNT_LOW     = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_HIGH_LATCH  = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_UPPER_LATCH = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_CONFIG      = 4'h7;

    // Field positions in the stack pointer and config registers
    localparam int BIT_FULL  = 7;
    localparam int BIT_UNDER = 6;
    localparam int BIT_ERREN = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // Operations issued by the instruction decoder
    typedef enum logic [3:0] {
        OP_NONE, OP_ADVANCE, OP_CALL, OP_RELATIVE_CALL, OP_JUMP,
        OP_RETURN, OP_RETURN_WITH_LITERAL, OP_RETURN_FROM_INTERRUPT, OP_PUSH, OP_POP, OP_INTACK
    } prs_op_e;

    // Decoder request bundle
    typedef struct packed {
        prs_op_e          op;
        logic [PC_W-1:0]  target;
        logic             fast;
        logic             hiPri;
    } prs_req_s;

    // Core registers saved by the shadow stack
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working;
        logic [7:0] bank;
    } prs_shadow_s;

    // Register port bundle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } prs_bus_s;

endpackage
